// [hw/rmul_top.sv]
// registered 16x16 multiplier with apb register access and three-state product pins
//
// Operation
// - The full 32-bit product of two 16-bit operands is delivered untruncated as a high and a low word.
// - Each operand is independently taken as two's complement or as unsigned magnitude.
// - A mixed signed and unsigned pair gives a correctly signed full product.
// - The X operand, Y operand and product registers each load on their own independent event.
// - Every input and output register captures only on the rising clock edge of its load event.
// - The high product word drives a port used for nothing else.
// - The low product word shares one port with Y input, driven by the device only while enabled.
// - All product outputs have three-state drive so they can be released from a shared bus.
// - New operands are accepted and a product delivered on every multiply cycle of at most 145 ns.
// - Squaring full-scale negative in fractional form is correct when right shift is set.
// - Signed selects register with their operand's bus write, round control with either bus write; a Y pin load keeps both.
// - Unregistered right shift drops the low word sign bit and shifts the high word down one.
// - Registered round adds one at bit 14 without right shift and bit 15 with it.
// - Each product word driver is high impedance while its unregistered disable is high.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module rmul_top
	import rmul_pkg::*;
(
	input  wire logic               pclk,              // bus clock
	input  wire logic               presetn,           // async reset, active low
	input  wire logic               psel,              // apb select
	input  wire logic               penable,           // apb access phase
	input  wire logic               pwrite,            // apb direction
	input  wire logic [APB_AW-1:0]  paddr,             // apb byte address
	input  wire logic [31:0]        pwdata,            // apb write data
	output logic      [31:0]        prdata,            // apb read data
	output logic                    pready,            // apb ready
	output logic                    pslverr,           // apb error on unmapped address
	output logic      [DATA_W-1:0]  product_high_word, // dedicated high word pins
	output logic                    product_high_oe,   // high word drive enable
	output logic      [DATA_W-1:0]  product_low_word,  // shared port, low word out
	output logic                    product_low_oe,    // shared port drive enable
	input  wire logic [DATA_W-1:0]  y_bus_in           // shared port, y data in
);
	typedef struct packed {
		logic [DATA_W-1:0] x_opnd;
		logic [DATA_W-1:0] y_opnd;
		logic              x_signed_select;
		logic              y_signed_select;
		logic              round_control;
		logic [3:0]        ctrl;
		logic [DATA_W-1:0] high_reg;
		logic [DATA_W-1:0] low_reg;
		logic [DATA_W-1:0] ysync1;
		logic [DATA_W-1:0] ysync2;
		logic              ack;
		logic              err;
		logic [31:0]       rdata;
	} rmul_state_t;

	rmul_state_t st;
	rmul_state_t next_st;

	function automatic logic mapped(input logic [APB_AW-1:0] a);
		mapped = (a == OFS_OPERAND_X) || (a == OFS_OPERAND_Y) || (a == OFS_CONTROL) ||
		         (a == OFS_STROBE) || (a == OFS_PROD_HIGH) || (a == OFS_PROD_LOW);
	endfunction

	// extend by one bit so both formats fit a signed 17x17 multiply
	function automatic logic signed [DATA_W:0] extend(input logic [DATA_W-1:0] v, input logic sgn);
		extend = {sgn & v[DATA_W-1], v};
	endfunction

	logic                     right_shift_format;
	logic                     output_register_bypass;
	logic signed [2*DATA_W+1:0] full_prod;
	logic        [PROD_W-1:0] raw_prod;
	logic        [PROD_W-1:0] round_add;
	logic        [PROD_W-1:0] sum_prod;
	logic        [DATA_W-1:0] high_comb;
	logic        [DATA_W-1:0] low_comb;
	logic                     setup;
	logic                     wr_now;
	logic                     x_load;
	logic                     y_load;
	logic                     y_pin_load;

	assign right_shift_format     = st.ctrl[CTL_SHIFT_BIT];
	assign output_register_bypass = st.ctrl[CTL_BYPASS_BIT];

	// array is combinational, so a product is ready well inside one multiply cycle
	always_comb begin
		full_prod = extend(st.x_opnd, st.x_signed_select) * extend(st.y_opnd, st.y_signed_select);
		raw_prod  = full_prod[PROD_W-1:0];
		round_add = '0;
		if (st.round_control) begin
			round_add[right_shift_format ? ROUND_POS_SHIFT : ROUND_POS_FRAC] = 1'b1;
		end
		sum_prod = raw_prod + round_add;
		if (right_shift_format) begin
			high_comb = sum_prod[PROD_W-1:DATA_W];
			low_comb  = sum_prod[DATA_W-1:0];
		end else begin
			// fractional form repeats the sign at the top of the low word
			high_comb = sum_prod[PROD_W-2:DATA_W-1];
			low_comb  = {sum_prod[PROD_W-1], sum_prod[DATA_W-2:0]};
		end
	end

	assign setup  = psel & ~penable;
	assign wr_now = psel & penable & st.ack & pwrite & ~st.err;
	assign x_load = wr_now & (paddr == OFS_OPERAND_X);
	assign y_pin_load = wr_now & (paddr == OFS_STROBE) & pwdata[STB_Y_FROM_PIN] & st.ctrl[CTL_LOW_DIS];
	assign y_load = (wr_now & (paddr == OFS_OPERAND_Y)) | y_pin_load;

	always_comb begin
		next_st        = st;
		next_st.ysync1 = y_bus_in;
		next_st.ysync2 = st.ysync1;
		next_st.ack    = setup;
		if (setup) begin
			next_st.err   = ~mapped(paddr);
			next_st.rdata = '0;
			unique case (paddr)
				OFS_OPERAND_X: next_st.rdata = {14'h0000, st.round_control, st.x_signed_select, st.x_opnd};
				OFS_OPERAND_Y: next_st.rdata = {14'h0000, st.round_control, st.y_signed_select, st.y_opnd};
				OFS_CONTROL:   next_st.rdata = {28'h0000000, st.ctrl};
				OFS_PROD_HIGH: next_st.rdata = {16'h0000, product_high_word};
				OFS_PROD_LOW:  next_st.rdata = {16'h0000, product_low_word};
				default:       next_st.rdata = '0;
			endcase
		end
		// constants stay put: an operand only changes on its own load
		if (x_load) begin
			next_st.x_opnd          = pwdata[DATA_W-1:0];
			next_st.x_signed_select = pwdata[OPR_SIGNED_BIT];
		end
		if (y_load) begin
			next_st.y_opnd          = y_pin_load ? st.ysync2 : pwdata[DATA_W-1:0];
			next_st.y_signed_select = y_pin_load ? st.y_signed_select : pwdata[OPR_SIGNED_BIT];
		end
		if (x_load | y_load) begin
			// pin loads keep the round setting; a bus write carries it
			next_st.round_control = y_pin_load ? st.round_control : pwdata[OPR_ROUND_BIT];
		end
		if (wr_now & (paddr == OFS_CONTROL)) begin
			next_st.ctrl = pwdata[3:0];
		end
		if (wr_now & (paddr == OFS_STROBE)) begin
			if (pwdata[STB_LOAD_HIGH]) begin
				next_st.high_reg = high_comb;
			end
			if (pwdata[STB_LOAD_LOW]) begin
				next_st.low_reg = low_comb;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st      <= '0;
			st.ctrl <= CTL_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign pready  = st.ack;
	assign pslverr = st.ack & st.err;
	assign prdata  = st.rdata;

	// bypass makes the output register transparent
	assign product_high_word = output_register_bypass ? high_comb : st.high_reg;
	assign product_low_word  = output_register_bypass ? low_comb : st.low_reg;
	assign product_high_oe   = ~st.ctrl[CTL_HIGH_DIS];
	assign product_low_oe    = ~st.ctrl[CTL_LOW_DIS];
endmodule

// [hw/rmul_pkg.sv]
// constants, register map and field layout of the registered multiplier
package rmul_pkg;
	localparam int          DATA_W          = 16;
	localparam int          PROD_W          = 32;
	localparam int          APB_AW          = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_OPERAND_X   = 8'h00;
	localparam logic [7:0]  OFS_OPERAND_Y   = 8'h04;
	localparam logic [7:0]  OFS_CONTROL     = 8'h08;
	localparam logic [7:0]  OFS_STROBE      = 8'h0C;
	localparam logic [7:0]  OFS_PROD_HIGH   = 8'h10;
	localparam logic [7:0]  OFS_PROD_LOW    = 8'h14;
	// operand register: signed select above the data
	localparam int          OPR_SIGNED_BIT  = 16;
	localparam int          OPR_ROUND_BIT   = 17;
	// control register fields
	localparam int          CTL_SHIFT_BIT   = 0;
	localparam int          CTL_BYPASS_BIT  = 1;
	localparam int          CTL_HIGH_DIS    = 2;
	localparam int          CTL_LOW_DIS     = 3;
	localparam logic [3:0]  CTL_RESET       = 4'hC;
	// strobe register fields, write one to pulse
	localparam int          STB_LOAD_HIGH   = 0;
	localparam int          STB_LOAD_LOW    = 1;
	localparam int          STB_Y_FROM_PIN  = 2;
	// rounding positions in the raw product
	localparam int          ROUND_POS_FRAC  = 14;
	localparam int          ROUND_POS_SHIFT = 15;
	// worst-case multiply cycle
	localparam int          MULT_CYCLE_NS   = 145;
	localparam int          CLK_PERIOD_NS   = 25;
	localparam int          MULT_CYCLES     = (MULT_CYCLE_NS / CLK_PERIOD_NS < 1) ? 1 : MULT_CYCLE_NS / CLK_PERIOD_NS;
endpackage

// [tb/rmul_assertions.sv]
// port checker for the registered multiplier
`timescale 1ns/1ps
module rmul_assertions
	import rmul_pkg::*;
(
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, // bus and control
	input wire logic [APB_AW-1:0] paddr,                                   // byte address
	input wire logic [31:0] pwdata, prdata,                                // bus data
	input wire logic [DATA_W-1:0] product_high_word, product_low_word,     // product pins
	input wire logic product_high_oe, product_low_oe                       // drive enables
);
	wire wr = psel && penable && pready && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_high_dis: assert property (wr && paddr == OFS_CONTROL |=> product_high_oe == !$past(pwdata[CTL_HIGH_DIS]))
		else $error("high enable wrong");
	a_low_dis: assert property (wr && paddr == OFS_CONTROL |=> product_low_oe == !$past(pwdata[CTL_LOW_DIS]))
		else $error("low enable wrong");
	a_oe_cause: assert property ($changed({product_high_oe, product_low_oe}) |-> $past(wr && paddr == OFS_CONTROL))
		else $error("enable moved without write");
	a_rd_high: assert property (pready && !pwrite && paddr == OFS_PROD_HIGH |-> prdata == {16'h0, product_high_word})
		else $error("high read differs from pins");
	a_rd_low: assert property (pready && !pwrite && paddr == OFS_PROD_LOW |-> prdata == {16'h0, product_low_word})
		else $error("low read differs from pins");
	a_word_cause: assert property ($changed({product_high_word, product_low_word}) |-> $past(wr))
		else $error("product moved without load");
	c_strobe: cover property (wr && paddr == OFS_STROBE);
	c_err: cover property (pready && pslverr);
	c_low_off: cover property (!product_low_oe && product_high_oe);
endmodule
bind rmul_top rmul_assertions u_rmul_assertions (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.product_high_word(product_high_word), .product_low_word(product_low_word),
	.product_high_oe(product_high_oe), .product_low_oe(product_low_oe));

// [tb/rmul_bus_side.sv]
// far-side system logic: resolves the shared y and low-word wire
`timescale 1ns/1ps
module rmul_bus_side (
	input  wire logic        pclk,     // bus clock
	input  wire logic [15:0] y_data,   // operand offered by the system
	input  wire logic        y_drive,  // system drives the wire
	input  wire logic [15:0] low_word, // device low word
	input  wire logic        low_oe,   // device drives the wire
	output logic      [15:0] wire_lvl  // resolved level
);
	logic [15:0] idle = 16'hA5A5;
	// an undriven wire must not look like a held value
	always @(posedge pclk) idle <= ~idle;
	assign wire_lvl = low_oe ? low_word : (y_drive ? y_data : idle);
endmodule

// [tb/rmul_top_tb_top.sv]
// self-checking bench for the registered multiplier
`timescale 1ns/1ps
module rmul_top_tb_top;
	import rmul_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ho, lo, y_drive = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [15:0] hw, lw, yb, y_data = 16'h0;
	int fail_count = 0, num_checks = 0, cyc = 0;
	rmul_top u_rmul_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .product_high_word(hw),
		.product_high_oe(ho), .product_low_word(lw), .product_low_oe(lo), .y_bus_in(yb));
	rmul_bus_side u_rmul_bus_side (.pclk(pclk), .y_data(y_data), .y_drive(y_drive), .low_word(lw), .low_oe(lo),
		.wire_lvl(yb));
	initial forever #12.5 pclk = ~pclk;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial forever @(posedge pclk) if (++cyc > 4000) begin
		fail_count++;
		print_verdict;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// ready, response and read data all taken at the rising edge that ends the access
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk); penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		r = prdata;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] fmt(logic [15:0] x, y, logic sx, sy, shf, rn);
		logic signed [33:0] p;
		logic [31:0] q;
		p = $signed({sx & x[15], x}) * $signed({sy & y[15], y});
		q = p[31:0] + (rn ? (shf ? 32'h8000 : 32'h4000) : 32'h0);
		return shf ? q : {q[30:15], q[31], q[14:0]};
	endfunction
	task automatic t_mul(input logic [15:0] x, y, input logic sx, sy, shf, rn);
		logic [31:0] e, r;
		e = fmt(x, y, sx, sy, shf, rn);
		apb(1, OFS_CONTROL, {31'h0, shf}, r);
		apb(1, OFS_OPERAND_X, {14'h0, rn, sx, x}, r);
		apb(1, OFS_OPERAND_Y, {14'h0, rn, sy, y}, r);
		apb(1, OFS_STROBE, 32'h3, r);
		apb(0, OFS_PROD_HIGH, 32'h0, r); chk(r, {16'h0, e[31:16]});
		apb(0, OFS_PROD_LOW, 32'h0, r); chk(r, {16'h0, e[15:0]});
		chk({hw, lw}, e);
		$display("mul %h x %h done", x, y);
	endtask
	// constant held in x, only y reloaded from the shared pins
	task automatic t_pin;
		logic [31:0] r;
		t_mul(16'h4000, 16'h0001, 0, 0, 1, 0);
		apb(1, OFS_CONTROL, 32'h9, r); chk(lo, 0);
		y_data <= 16'h0008; y_drive <= 1;
		repeat (3) @(posedge pclk);
		apb(1, OFS_STROBE, 32'h4, r);
		y_drive <= 0;
		apb(1, OFS_STROBE, 32'h1, r);
		apb(0, OFS_PROD_HIGH, 32'h0, r); chk(r, 32'h2);
		apb(0, OFS_PROD_LOW, 32'h0, r); chk(r, 32'h4000);
		$display("pin test done");
	endtask
	task automatic t_basic;
		logic [31:0] r;
		apb(0, OFS_CONTROL, 32'h0, r); chk(r, {28'h0, CTL_RESET});
		chk({ho, lo}, 0);
		apb(0, 8'h20, 32'h0, r); chk({r, err}, {32'h0, 1'b1});
		$display("basic test done");
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_basic;
		for (int m = 0; m < 4; m++) t_mul(16'h8001, 16'hFFFF, m[0], m[1], 1, 0);
		t_mul(16'h8000, 16'h8000, 1, 1, 1, 1);
		t_mul(16'h1234, 16'h9678, 1, 1, 0, 1);
		t_pin;
		print_verdict;
	end
endmodule
